/* File: inc/ddr2_col_pkg.sv */
// Shared constants and carriers for the DDR2 column burst block.
// Assumes one page of the open row is held locally; link runs on ck_link.
package ddr2_col_pkg;
    localparam int COL_W = 10;
    localparam int PAGE_COLS = 1024;
    localparam int BEAT_W = 16;
    localparam int NBANK = 8;
    localparam int BANK_W = 3;
    localparam int ADDR_W = 13;
    localparam int SCHED_D = 16;
    localparam int SYNC_W = 14;
    localparam int AP_A_BIT = 10;
    localparam int ORDER_BIT = 3;
    localparam logic [2:0] BL8_CODE = 3'h3;
    localparam logic [2:0] CL_RST = 3'h3;
    localparam logic [2:0] AL_RST = 3'h0;
    localparam logic [4:0] WR_CLKS = 5'h2;
    localparam logic [4:0] HALF_BL4 = 5'h2;
    localparam logic [4:0] HALF_BL8 = 5'h4;
    localparam logic [2:0] BA_MODE = 3'h0;
    localparam logic [2:0] BA_EXT = 3'h1;
    localparam logic [1:0] DQS_DATA = 2'h1;
    localparam logic [1:0] DQS_LOW = 2'h0;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [BANK_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
    } cmd_pins_t;

    // Two beats per clock: low half on the rising strobe edge
    typedef struct packed {
        logic [2*BEAT_W-1:0] dq;
        logic [3:0] dm;
    } wr_pins_t;

    typedef struct packed {
        logic [2*BEAT_W-1:0] dq;
        logic [1:0] dqs;
        logic dq_oe_n;
        logic dqs_oe_n;
    } rd_pins_t;

    typedef struct packed {
        logic vld;
        logic wr;
        logic [COL_W-1:0] col;
    } sched_t;

    typedef enum {CMD_NOP, CMD_READ, CMD_WRITE, CMD_PRE, CMD_ACT, CMD_MODE} cmd_t;
    typedef enum logic [1:0] {BURST_IDLE, BURST_RD, BURST_WR} burst_t;
endpackage

/* File: hw/burst_col_gen.sv */
// Low three column bits for one beat of a burst.
// Assumes start and beat are stable within the caller's cycle.
`timescale 1ns/100ps
module burst_col_gen (
    input wire logic [2:0] start,
    input wire logic [2:0] beat,
    input wire logic bl8,
    input wire logic ilv,
    output logic [2:0] col
);
    // Interleave flips bits; sequential adds inside the nibble
    always_comb begin
        if (ilv) begin
            col = bl8 ? (start ^ beat) : {start[2], start[1:0] ^ beat[1:0]};
        end else begin
            col[1:0] = 2'(start[1:0] + beat[1:0]);
            col[2] = bl8 ? (start[2] ^ beat[2]) : start[2];
        end
    end
endmodule // burst_col_gen

/* File: hw/ddr2_column_burst_and_precharge.sv */
// Column burst, latency, strobe, mask and precharge logic of the memory.
// Link pins are on ck_link; status is carried back to clk_sys.
`timescale 1ns/100ps
module ddr2_column_burst_and_precharge (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ck_link,
    input wire ddr2_col_pkg::cmd_pins_t cmd,
    input wire ddr2_col_pkg::wr_pins_t wr_in,
    output ddr2_col_pkg::rd_pins_t rd_out,
    output logic [ddr2_col_pkg::NBANK-1:0] banks_open,
    output logic burst_interleave,
    output logic burst_len8,
    output logic [3:0] read_latency
);
    typedef struct packed {
        logic [2:0] rst_sync;
        logic rst_ok;
        logic [2:0] cl;
        logic [2:0] al;
        logic bl8;
        logic ilv;
        logic [ddr2_col_pkg::NBANK-1:0] bank_open;
        logic [ddr2_col_pkg::NBANK-1:0][4:0] ap_cnt;
        ddr2_col_pkg::sched_t [ddr2_col_pkg::SCHED_D-1:0] sched;
        ddr2_col_pkg::burst_t mode;
        logic [ddr2_col_pkg::COL_W-1:0] start;
        logic [1:0] pair;
        logic [2:0] cap;
        logic [4:0] hrd;
        logic [4:0] hwr;
        ddr2_col_pkg::rd_pins_t pins;
        logic [ddr2_col_pkg::PAGE_COLS-1:0][ddr2_col_pkg::BEAT_W-1:0] page;
    } link_state_t;

    typedef struct packed {
        logic [2:0][ddr2_col_pkg::SYNC_W-1:0] sync;
        logic [ddr2_col_pkg::SYNC_W-1:0] stat;
    } sys_state_t;

    link_state_t lk_r, lk_nxt;
    sys_state_t sy_r, sy_nxt;
    ddr2_col_pkg::cmd_t cmd_now;
    logic [3:0] rl;
    logic [3:0] wl;
    logic [4:0] half_bl;
    logic [1:0] last_pair;
    logic ld;
    logic [1:0][2:0] gs;
    logic [1:0][1:0] gp;
    logic [3:0][2:0] col_lo;
    logic [3:0][ddr2_col_pkg::COL_W-1:0] col;

    // Command truth table sampled on each rising link edge
    function automatic ddr2_col_pkg::cmd_t decode(input ddr2_col_pkg::cmd_pins_t p);
        decode = ddr2_col_pkg::CMD_NOP;
        if (!p.cs_n) begin
            case ({p.ras_n, p.cas_n, p.we_n})
                3'h5: decode = ddr2_col_pkg::CMD_READ;
                3'h4: decode = ddr2_col_pkg::CMD_WRITE;
                3'h2: decode = ddr2_col_pkg::CMD_PRE;
                3'h3: decode = ddr2_col_pkg::CMD_ACT;
                3'h0: decode = ddr2_col_pkg::CMD_MODE;
                default: decode = ddr2_col_pkg::CMD_NOP;
            endcase
        end
    endfunction

    // Latencies derived from the loaded mode values
    assign cmd_now = decode(cmd);
    assign rl = 4'(lk_r.al) + 4'(lk_r.cl);
    assign wl = rl - 4'h1;
    assign half_bl = lk_r.bl8 ? ddr2_col_pkg::HALF_BL8 : ddr2_col_pkg::HALF_BL4;
    assign last_pair = 2'(half_bl - 5'h1);
    assign ld = lk_r.sched[0].vld;

    // Use 0 is the pair on the wire now, use 1 the pair to launch next
    assign gs[0] = lk_r.start[2:0];
    assign gp[0] = lk_r.pair;
    assign gs[1] = ld ? lk_r.sched[0].col[2:0] : lk_r.start[2:0];
    assign gp[1] = ld ? 2'h0 : 2'(lk_r.pair + 2'h1);

    for (genvar g = 0; g < 4; g++) begin : g_col
        burst_col_gen u_col (
            .start(gs[g/2]),
            .beat({gp[g/2], 1'(g % 2)}),
            .bl8(lk_r.bl8),
            .ilv(lk_r.ilv),
            .col(col_lo[g])
        );
        if (g < 2) begin : g_cur
            assign col[g] = {lk_r.start[ddr2_col_pkg::COL_W-1:3], col_lo[g]};
        end else begin : g_nxt
            assign col[g] = {ld ? lk_r.sched[0].col[ddr2_col_pkg::COL_W-1:3]
                                : lk_r.start[ddr2_col_pkg::COL_W-1:3], col_lo[g]};
        end
    end

    // Link domain next state
    always_comb begin
        lk_nxt = lk_r;
        lk_nxt.rst_sync = {lk_r.rst_sync[1:0], rst_n};
        if (lk_r.rst_sync[1] == lk_r.rst_sync[2]) begin
            lk_nxt.rst_ok = lk_r.rst_sync[2];
        end
        for (int i = 0; i < ddr2_col_pkg::SCHED_D - 1; i++) begin
            lk_nxt.sched[i] = lk_r.sched[i+1];
        end
        lk_nxt.sched[ddr2_col_pkg::SCHED_D-1] = '0;
        lk_nxt.hrd = (lk_r.hrd == 5'h1f) ? lk_r.hrd : 5'(lk_r.hrd + 5'h1);
        lk_nxt.hwr = (lk_r.hwr == 5'h1f) ? lk_r.hwr : 5'(lk_r.hwr + 5'h1);
        // Auto-precharge timers count from the command, full burst
        for (int b = 0; b < ddr2_col_pkg::NBANK; b++) begin
            if (lk_r.ap_cnt[b] != 5'h0) begin
                lk_nxt.ap_cnt[b] = 5'(lk_r.ap_cnt[b] - 5'h1);
                if (lk_r.ap_cnt[b] == 5'h1) begin
                    lk_nxt.bank_open[b] = 1'b0;
                end
            end
        end
        case (cmd_now)
            ddr2_col_pkg::CMD_READ: begin
                // A read behind one still awaiting data keeps the older count
                if (lk_r.hrd >= 5'(rl)) begin
                    lk_nxt.hrd = 5'h0;
                end
                lk_nxt.sched[rl - 4'h1] = {1'b1, 1'b0, cmd.addr[ddr2_col_pkg::COL_W-1:0]};
                if (cmd.addr[ddr2_col_pkg::AP_A_BIT]) begin
                    lk_nxt.ap_cnt[cmd.ba] = 5'(lk_r.al) + half_bl;
                end
            end
            ddr2_col_pkg::CMD_WRITE: begin
                if (lk_r.hwr >= 5'(wl)) begin
                    lk_nxt.hwr = 5'h0;
                end
                lk_nxt.sched[wl - 4'h1] = {1'b1, 1'b1, cmd.addr[ddr2_col_pkg::COL_W-1:0]};
                if (cmd.addr[ddr2_col_pkg::AP_A_BIT]) begin
                    lk_nxt.ap_cnt[cmd.ba] = 5'(wl) + half_bl + ddr2_col_pkg::WR_CLKS;
                end
            end
            ddr2_col_pkg::CMD_PRE: begin
                if (cmd.addr[ddr2_col_pkg::AP_A_BIT]) begin
                    lk_nxt.bank_open = '0;
                end else begin
                    lk_nxt.bank_open[cmd.ba] = 1'b0;
                end
            end
            ddr2_col_pkg::CMD_ACT: begin
                lk_nxt.bank_open[cmd.ba] = 1'b1;
            end
            ddr2_col_pkg::CMD_MODE: begin
                if (cmd.ba == ddr2_col_pkg::BA_MODE) begin
                    lk_nxt.bl8 = (cmd.addr[2:0] == ddr2_col_pkg::BL8_CODE);
                    lk_nxt.ilv = cmd.addr[ddr2_col_pkg::ORDER_BIT];
                    lk_nxt.cl = cmd.addr[6:4];
                end else if (cmd.ba == ddr2_col_pkg::BA_EXT) begin
                    lk_nxt.al = cmd.addr[5:3];
                end
            end
            default: begin
            end
        endcase
        // Burst engine: capture writes, stream reads
        case (lk_r.mode)
            ddr2_col_pkg::BURST_WR: begin
                // Controller holds data for the pair of this cycle
                for (int k = 0; k < 4; k++) begin
                    if (!wr_in.dm[k]) begin
                        lk_nxt.page[col[k/2]][8*(k%2) +: 8] = wr_in.dq[8*k +: 8];
                    end
                end
                lk_nxt.cap = 3'(lk_r.cap + 3'h1);
                lk_nxt.pair = 2'(lk_r.pair + 2'h1);
                if (lk_r.pair == last_pair) begin
                    lk_nxt.mode = ddr2_col_pkg::BURST_IDLE;
                end
            end
            ddr2_col_pkg::BURST_RD: begin
                lk_nxt.pair = 2'(lk_r.pair + 2'h1);
                if (lk_r.pair == last_pair) begin
                    lk_nxt.mode = ddr2_col_pkg::BURST_IDLE;
                end
            end
            default: begin
                lk_nxt.cap = 3'h0; // Idle clears so a later BL4 load sees no stale count
            end
        endcase
        // A due burst replaces the one in flight; this is the interrupt path
        if (ld) begin
            lk_nxt.mode = lk_r.sched[0].wr ? ddr2_col_pkg::BURST_WR
                                          : ddr2_col_pkg::BURST_RD;
            lk_nxt.start = lk_r.sched[0].col;
            lk_nxt.pair = 2'h0;
            lk_nxt.cap = 3'h0;
        end
        // Read pins; preamble in the cycle before the first pair
        lk_nxt.pins.dq_oe_n = (lk_nxt.mode != ddr2_col_pkg::BURST_RD);
        lk_nxt.pins.dqs = ddr2_col_pkg::DQS_LOW;
        lk_nxt.pins.dqs_oe_n = !(lk_r.sched[1].vld && !lk_r.sched[1].wr);
        if (lk_nxt.mode == ddr2_col_pkg::BURST_RD) begin
            lk_nxt.pins.dq = {lk_r.page[col[3]], lk_r.page[col[2]]};
            lk_nxt.pins.dqs = ddr2_col_pkg::DQS_DATA;
            lk_nxt.pins.dqs_oe_n = 1'b0;
        end
        if (!lk_r.rst_ok) begin
            lk_nxt.cl = ddr2_col_pkg::CL_RST;
            lk_nxt.al = ddr2_col_pkg::AL_RST;
            lk_nxt.bl8 = 1'b1;
            lk_nxt.ilv = 1'b0;
            lk_nxt.bank_open = '0;
            lk_nxt.ap_cnt = '0;
            lk_nxt.sched = '0;
            lk_nxt.mode = ddr2_col_pkg::BURST_IDLE;
            lk_nxt.start = '0;
            lk_nxt.pair = 2'h0;
            lk_nxt.cap = 3'h0;
            lk_nxt.hrd = 5'h1f;
            lk_nxt.hwr = 5'h1f;
            lk_nxt.pins = '{dq: '0, dqs: ddr2_col_pkg::DQS_LOW, dq_oe_n: 1'b1, dqs_oe_n: 1'b1};
        end
    end

    always_ff @(posedge ck_link) begin
        lk_r <= lk_nxt;
    end

    // Status crossing; bits are quasi-static, each taken once two stages agree
    always_comb begin
        sy_nxt = sy_r;
        sy_nxt.sync[0] = {lk_r.bank_open, lk_r.ilv, lk_r.bl8, rl};
        sy_nxt.sync[1] = sy_r.sync[0];
        sy_nxt.sync[2] = sy_r.sync[1];
        for (int i = 0; i < ddr2_col_pkg::SYNC_W; i++) begin
            if (sy_r.sync[1][i] == sy_r.sync[2][i]) begin
                sy_nxt.stat[i] = sy_r.sync[2][i];
            end
        end
        if (!rst_n) begin
            sy_nxt.stat = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        sy_r <= sy_nxt;
    end

    assign rd_out = lk_r.pins;
    assign {banks_open, burst_interleave, burst_len8, read_latency} = sy_r.stat;

    // Checks on the link side
    default clocking cb @(posedge ck_link);
    endclocking
    default disable iff (!lk_r.rst_ok);

    sequence rd_start_s;
        rd_out.dq_oe_n ##1 !rd_out.dq_oe_n;
    endsequence

    sequence preamble_s;
        !rd_out.dqs_oe_n && rd_out.dqs == ddr2_col_pkg::DQS_LOW;
    endsequence

    rd_latency_a: assert property ($fell(rd_out.dq_oe_n) |-> lk_r.hrd == 5'(rl))
        else $error("read data not at read latency");
    wr_latency_a: assert property ($rose(lk_r.mode == ddr2_col_pkg::BURST_WR)
        |-> lk_r.hwr == 5'(wl))
        else $error("write capture not at write latency");
    rd_preamble_a: assert property (rd_start_s |-> $past(rd_out.dqs_oe_n == 1'b0
        && rd_out.dqs == ddr2_col_pkg::DQS_LOW))
        else $error("no strobe preamble before read data");
    preamble_next_a: assert property (preamble_s and rd_out.dq_oe_n
        |=> !rd_out.dq_oe_n && rd_out.dqs == ddr2_col_pkg::DQS_DATA)
        else $error("preamble not followed by data");
    ilv_order_a: assert property (lk_r.mode != ddr2_col_pkg::BURST_IDLE && lk_r.ilv
        && lk_r.bl8 |-> col_lo[1] == (lk_r.start[2:0] ^ {lk_r.pair, 1'b1}))
        else $error("interleaved column wrong");
    seq_order_a: assert property (lk_r.mode != ddr2_col_pkg::BURST_IDLE && !lk_r.ilv
        && lk_r.bl8 |-> col_lo[1][2] == (lk_r.start[2] ^ lk_r.pair[1])
        && col_lo[1][1:0] == 2'(lk_r.start[1:0] + {lk_r.pair[0], 1'b1}))
        else $error("sequential column wrong");
    pre_all_a: assert property (cmd_now == ddr2_col_pkg::CMD_PRE
        && cmd.addr[ddr2_col_pkg::AP_A_BIT] |=> lk_r.bank_open == '0)
        else $error("precharge all left a bank open");
    pre_one_a: assert property (cmd_now == ddr2_col_pkg::CMD_PRE
        && !cmd.addr[ddr2_col_pkg::AP_A_BIT] |=> !lk_r.bank_open[$past(cmd.ba)])
        else $error("precharged bank still open");
    wr_ignore_a: assert property (lk_r.cap <= 3'(half_bl))
        else $error("more write pairs taken than burst");
    rd_mask_a: assert property (lk_r.mode == ddr2_col_pkg::BURST_RD
        && !ld |=> $stable(lk_r.page))
        else $error("page changed during read");
    mask_keep_a: assert property (lk_r.mode == ddr2_col_pkg::BURST_WR && wr_in.dm[0]
        && col[0] != col[1] |=> lk_r.page[$past(col[0])][7:0]
        == $past(lk_r.page[col[0]][7:0]))
        else $error("masked lane was written");
    seamless_a: assert property (lk_r.mode == ddr2_col_pkg::BURST_RD
        && lk_r.pair == last_pair && ld && !lk_r.sched[0].wr
        |=> !rd_out.dq_oe_n)
        else $error("gap between seamless reads");
    for (genvar b = 0; b < ddr2_col_pkg::NBANK; b++) begin : g_apchk
        ap_close_a: assert property (lk_r.ap_cnt[b] == 5'h1 |=> !lk_r.bank_open[b])
            else $error("auto precharge did not close bank");
    end
endmodule // ddr2_column_burst_and_precharge

/* File: dv/ddr2_ctl_model.sv */
// Controller model: drives the command and write-data pins of the memory.
// Assumes a free-running ck_link; every pin changes at its falling edge.
`timescale 1ns/100ps
module ddr2_ctl_model (
    input wire logic ck_link,
    output ddr2_col_pkg::cmd_pins_t cmd,
    output ddr2_col_pkg::wr_pins_t wr_in
);
    // Deselected and quiet at time zero
    initial begin
        cmd = '1;
        wr_in = '0;
    end
    // One command for one clock; code is cs, ras, cas, we
    task automatic issue(input logic [3:0] code, input logic [2:0] ba, input logic [12:0] a);
        @(negedge ck_link);
        cmd = {code, ba, a};
        @(negedge ck_link);
        cmd = {4'hf, ~ba, ~a}; // Deselected lines must not keep the old address
    endtask
    // Burst of four pairs, first pair in the cycle after the write latency
    task automatic write8(input logic [2:0] ba, input logic [9:0] col, input int wl,
                          input logic [127:0] d, input logic [15:0] m);
        issue(4'h4, ba, {3'h0, col});
        repeat (wl) @(negedge ck_link);
        for (int k = 0; k < 4; k++) begin
            wr_in = {d[32*k +: 32], m[4*k +: 4]};
            @(negedge ck_link);
        end
        wr_in = {~d[127:96], 4'hf}; // Junk after the burst, masks high into reads
    endtask
endmodule // ddr2_ctl_model

/* File: dv/test_ddr2_column_burst_and_precharge.sv */
// Self-checking bench for the column burst block and a controller model.
// Assumes the design package is compiled first; both clocks are made here.
`timescale 1ns/100ps
module test_ddr2_column_burst_and_precharge;
    logic clk_sys;
    logic rst_n;
    logic ck_link;
    ddr2_col_pkg::cmd_pins_t cmd;
    ddr2_col_pkg::wr_pins_t wr_in;
    ddr2_col_pkg::rd_pins_t rd_out;
    logic [7:0] banks_open;
    logic burst_interleave;
    logic burst_len8;
    logic [3:0] read_latency;
    int n_fail = 0;
    int cmp_count = 0;
    int rl = 3;
    logic bl8 = 1'b1;
    logic ilv = 1'b0;
    logic [15:0] page [8];

    ddr2_column_burst_and_precharge i_ddr2_column_burst_and_precharge (.clk_sys(clk_sys),
        .rst_n(rst_n), .ck_link(ck_link), .cmd(cmd), .wr_in(wr_in), .rd_out(rd_out),
        .banks_open(banks_open), .burst_interleave(burst_interleave),
        .burst_len8(burst_len8), .read_latency(read_latency));
    ddr2_ctl_model i_ddr2_ctl_model (.ck_link(ck_link), .cmd(cmd), .wr_in(wr_in));

    // System clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Link clock, offset so its edges never meet the system clock's
    initial begin
        ck_link = 1'b0;
        #3.3;
        forever #7.5 ck_link = ~ck_link;
    end

    task automatic chk_pins(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Status crosses domains, so give it ten system clocks to settle
    task automatic chk_stat(input logic [13:0] e);
        repeat (10) @(negedge clk_sys);
        cmp_count++;
        if ({banks_open, burst_len8, burst_interleave, read_latency} !== e) begin
            n_fail++;
            $display("MISMATCH status expected %h seen %h", e,
                     {banks_open, burst_len8, burst_interleave, read_latency});
        end
    endtask
    function automatic logic [2:0] exp_col(input logic [2:0] s, input logic [2:0] b);
        return ilv ? (s ^ b) : {s[2] ^ b[2], s[1:0] + b[1:0]};
    endfunction
    // Write bank 1 and fold unmasked bytes into the expected page
    task automatic wr_do(input logic [2:0] s, input logic [127:0] d, input logic [15:0] m);
        i_ddr2_ctl_model.write8(3'h1, {7'h00, s}, rl - 1, d, m);
        for (int b = 0; b < 8; b++)
            for (int l = 0; l < 2; l++)
                if (!m[2*b+l]) page[exp_col(s, b[2:0])][8*l +: 8] = d[16*b+8*l +: 8];
        repeat (12) @(negedge ck_link);
    endtask
    // Reads two clocks apart, then preamble, data pairs and release
    task automatic rd_chk(input logic [2:0] c0, input logic [2:0] c1, input int nrd,
                          input logic ap);
        int np;
        int q;
        logic [2:0] s;
        np = bl8 ? 4 : 2;
        i_ddr2_ctl_model.issue(4'h5, 3'h1, {2'h0, ap, 7'h00, c0});
        if (nrd == 2) i_ddr2_ctl_model.issue(4'h5, 3'h1, {10'h000, c1});
        repeat (rl - 2 * nrd + 1) @(negedge ck_link);
        chk_pins("preamble", 32'h2, {rd_out.dqs, rd_out.dq_oe_n, rd_out.dqs_oe_n});
        for (int p = 0; p < np * nrd; p++) begin
            @(negedge ck_link);
            s = (p < np) ? c0 : c1;
            q = 2 * (p % np);
            chk_pins("dq", {page[exp_col(s, q[2:0] + 3'h1)], page[exp_col(s, q[2:0])]},
                     rd_out.dq);
            chk_pins("strobe", 32'h4, {rd_out.dqs, rd_out.dq_oe_n, rd_out.dqs_oe_n});
        end
        @(negedge ck_link);
        chk_pins("release", 32'h3, {rd_out.dq_oe_n, rd_out.dqs_oe_n});
        repeat (12) @(negedge ck_link);
    endtask

    task automatic t_banks();
        i_ddr2_ctl_model.issue(4'h3, 3'h2, 13'h0000);
        i_ddr2_ctl_model.issue(4'h3, 3'h5, 13'h0000);
        chk_stat({8'h24, 2'h2, 4'h3});
        i_ddr2_ctl_model.issue(4'h2, 3'h2, 13'h0000);
        chk_stat({8'h20, 2'h2, 4'h3});
        i_ddr2_ctl_model.issue(4'h3, 3'h0, 13'h0000);
        i_ddr2_ctl_model.issue(4'h2, 3'h5, 13'h0400);
        chk_stat({8'h00, 2'h2, 4'h3});
    endtask
    // Additive latency of one, two writes over one nibble pair, second masked
    task automatic t_write_read();
        i_ddr2_ctl_model.issue(4'h0, 3'h1, 13'h0008);
        rl = 4;
        chk_stat({8'h00, 2'h2, 4'h4});
        i_ddr2_ctl_model.issue(4'h3, 3'h1, 13'h0000);
        wr_do(3'h6, 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0, 16'h0000);
        wr_do(3'h6, 128'h1122_3344_5566_7788_99aa_bbcc_ddee_ff00, 16'h0c31);
        rd_chk(3'h5, 3'h0, 1, 1'b0);
    endtask
    task automatic t_interleave_ap();
        i_ddr2_ctl_model.issue(4'h0, 3'h0, 13'h003b);
        ilv = 1'b1;
        chk_stat({8'h02, 2'h3, 4'h4});
        rd_chk(3'h3, 3'h0, 1, 1'b1);
        chk_stat({8'h00, 2'h3, 4'h4});
    endtask
    task automatic t_seamless();
        i_ddr2_ctl_model.issue(4'h0, 3'h1, 13'h0000);
        i_ddr2_ctl_model.issue(4'h0, 3'h0, 13'h0032);
        {bl8, ilv, rl} = {2'h0, 32'd3};
        chk_stat({8'h00, 2'h0, 4'h3});
        rd_chk(3'h1, 3'h6, 2, 1'b0);
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Main sequence; reset spans eight rising link edges for the link synchronizer
    initial begin
        rst_n = 1'b0;
        repeat (13) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (6) @(negedge ck_link);
        chk_stat({8'h00, 2'h2, 4'h3});
        t_banks();
        t_write_read();
        t_interleave_ap();
        t_seamless();
        summarize();
    end
    // About 190 link clocks of traffic; far longer means a hang
    initial begin
        #40000;
        n_fail++;
        $display("MISMATCH watchdog expected done seen hang");
        summarize();
    end
endmodule // test_ddr2_column_burst_and_precharge
